// ==== common/vms_pkg.sv ====
// Package of constants and types for the output-voltage margin and slew control
// ==========================================================================
// How it works
// - The reference never jumps but walks to each new target one DAC step at a time.
// - The slew step select code 00/01/10/11 spaces steps 4/8/16/32 us apart, default 00.
// - Margin changes slew at the same step interval chosen by the slew step select field.
// - A fine trim write or margin enable waits 50 us, then one step interval, before the first step.
// - Margin level bits 7:4 are the high code, 0000 is +0%, 11xx is +12.0%, default 0101.
// - Margin level bits 3:0 are the low code, 0000 is -0%, 11xx is -11.6%, default 0101.
// - Margining acts only when the operation command enables high or low margin.
// - Active margin and fine trim combine into one target by applying both factors.
// - A margin level written first is used once margining is later enabled.
// - Margining enabled with no level written uses the current (default) high or low code.
// - A margin level write while margining is active retargets with the same delay.
// - Threshold code 0xx is 10.2 V, 101 is 4.25 V (default), 110 is 6.0 V, 111 is 8.1 V.
// - The five-bit fine trim code moves the target in 0.75% steps within +/-9%.
// - The target is nominal times the fine trim factor times the margin factor.
package vms_pkg;
  // ==========================================================================
  // Command codes
  localparam logic [7:0] VMS_CMD_OPERATION = 8'h01;
  localparam logic [7:0] VMS_CMD_FINE_TRIM = 8'hd4;
  localparam logic [7:0] VMS_CMD_MARGIN = 8'hd5;
  localparam logic [7:0] VMS_CMD_THRESHOLD = 8'hd6;
  localparam logic [7:0] VMS_CMD_SOFT_START = 8'hd2;
  // ==========================================================================
  // Fields and reset values
  localparam int VMS_MH_LSB = 4;
  localparam int VMS_SST_LSB = 2;
  localparam int VMS_OP_MARGIN_LSB = 2;
  localparam logic [1:0] VMS_OP_MARGIN_LOW = 2'h1;
  localparam logic [1:0] VMS_OP_MARGIN_HIGH = 2'h2;
  localparam logic [7:0] VMS_MARGIN_RST = 8'h55;
  localparam logic [7:0] VMS_THRESH_RST = 8'h05;
  localparam logic [4:0] VMS_TRIM_RST = 5'h10;
  localparam logic [1:0] VMS_SST_RST = 2'h0;
  // Threshold in tens of millivolts
  localparam logic [9:0] VMS_UV_10V2 = 10'h3fc;
  localparam logic [9:0] VMS_UV_4V25 = 10'h1a9;
  localparam logic [9:0] VMS_UV_6V0 = 10'h258;
  localparam logic [9:0] VMS_UV_8V1 = 10'h32a;
  // ==========================================================================
  // Timing
  localparam int VMS_CLK_MHZ = 100;
  localparam int VMS_STEP_BASE_US = 4;
  localparam int VMS_START_DELAY_US = 50;
  localparam int VMS_STEP_BASE_CYC = VMS_STEP_BASE_US * VMS_CLK_MHZ;
  localparam int VMS_START_DELAY_CYC = VMS_START_DELAY_US * VMS_CLK_MHZ;
  // Scale: factors are in units of 1/10000 (10000 = 1.0)
  localparam int VMS_UNITY = 10000;
  // ==========================================================================
  // Types
  typedef struct packed {
    logic valid;
    logic [7:0] cmd;
    logic [7:0] data;
  } vms_wr_t;
  typedef enum logic [2:0] {
    VMS_IDLE = 3'b001,
    VMS_WAIT = 3'b010,
    VMS_SLEW = 3'b100
  } vms_state_t;
endpackage : vms_pkg

// ==== rtl/vms_ctrl.sv ====
// Margin, fine trim and reference slew control for the buck converter
`timescale 1ns/100ps
`default_nettype none
module vms_ctrl
  import vms_pkg::*;
#(
  parameter int DAC_W = 16,
  parameter int NOMINAL_CODE = 16'h8000,
  parameter int START_DELAY_CYC = VMS_START_DELAY_CYC
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire vms_wr_t wr,
  input wire logic [7:0] rd_cmd,
  output logic [7:0] rd_data,
  output logic [DAC_W-1:0] ref_code,
  output logic [DAC_W-1:0] target_code,
  output logic slewing,
  output logic [2:0] supply_threshold_code,
  output logic [9:0] uv_threshold_cv
);
  if (DAC_W < 8 || DAC_W > 20 || START_DELAY_CYC < 1 ||
      NOMINAL_CODE >= (1 << DAC_W)) begin : g_bad_param
    $error("vms_ctrl: unsupported parameters");
  end

  // ==========================================================================
  // Percentage tables, factor in 1/10000
  function automatic int high_factor(input logic [3:0] c);
    case (c)
      4'h0: high_factor = 10000;
      4'h1: high_factor = 10090;
      4'h2: high_factor = 10180;
      4'h3: high_factor = 10280;
      4'h4: high_factor = 10370;
      4'h5: high_factor = 10470;
      4'h6: high_factor = 10570;
      4'h7: high_factor = 10670;
      4'h8: high_factor = 10770;
      4'h9: high_factor = 10880;
      4'ha: high_factor = 10990;
      4'hb: high_factor = 11090;
      default: high_factor = 11200;
    endcase
  endfunction : high_factor

  function automatic int low_factor(input logic [3:0] c);
    case (c)
      4'h0: low_factor = 10000;
      4'h1: low_factor = 9890;
      4'h2: low_factor = 9790;
      4'h3: low_factor = 9680;
      4'h4: low_factor = 9580;
      4'h5: low_factor = 9480;
      4'h6: low_factor = 9380;
      4'h7: low_factor = 9290;
      4'h8: low_factor = 9190;
      4'h9: low_factor = 9100;
      4'ha: low_factor = 9015;
      4'hb: low_factor = 8930;
      default: low_factor = 8840;
    endcase
  endfunction : low_factor

  function automatic int trim_factor(input logic [4:0] c);
    int s;
    s = 0;
    if (c[4:2] == 3'b111) begin
      s = 12;
    end else if (c[4:2] == 3'b000) begin
      s = -12;
    end else if (c[4]) begin
      s = int'(c[3:0]);
    end else begin
      s = int'(c[3:0]) - 15;
    end
    trim_factor = VMS_UNITY + s * 75;
  endfunction : trim_factor

  // ==========================================================================
  // Command registers
  logic [7:0] margin_q;
  logic [7:0] thresh_q;
  logic [4:0] trim_q;
  logic [1:0] sst_q;
  logic [1:0] margin_mode_q;
  logic retarget;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      margin_q <= VMS_MARGIN_RST;
      thresh_q <= VMS_THRESH_RST;
      trim_q <= VMS_TRIM_RST;
      sst_q <= VMS_SST_RST;
      margin_mode_q <= 2'h0;
    end else if (wr.valid) begin
      unique case (wr.cmd)
        VMS_CMD_MARGIN: margin_q <= wr.data;
        VMS_CMD_THRESHOLD: thresh_q <= wr.data;
        VMS_CMD_FINE_TRIM: trim_q <= wr.data[4:0];
        VMS_CMD_SOFT_START: sst_q <= wr.data[VMS_SST_LSB +: 2];
        VMS_CMD_OPERATION: margin_mode_q <= wr.data[VMS_OP_MARGIN_LSB +: 2];
        default: ;
      endcase
    end
  end

  // Trim write, margin enable, or margin write while margining all restart the delay
  always_comb begin
    retarget = 1'b0;
    if (wr.valid) begin
      if (wr.cmd == VMS_CMD_FINE_TRIM) begin
        retarget = 1'b1;
      end
      if (wr.cmd == VMS_CMD_OPERATION) begin
        retarget = wr.data[VMS_OP_MARGIN_LSB +: 2] != margin_mode_q;
      end
      if (wr.cmd == VMS_CMD_MARGIN && margin_mode_q != 2'h0) begin
        retarget = 1'b1;
      end
    end
  end

  // ==========================================================================
  // Combined target
  logic [DAC_W-1:0] target_d;
  always_comb begin
    longint prod;
    int mf;
    prod = 0;
    mf = VMS_UNITY;
    unique case (margin_mode_q)
      VMS_OP_MARGIN_HIGH: mf = high_factor(margin_q[VMS_MH_LSB +: 4]);
      VMS_OP_MARGIN_LOW: mf = low_factor(margin_q[3:0]);
      default: mf = VMS_UNITY;
    endcase
    prod = longint'(NOMINAL_CODE) * trim_factor(trim_q) * mf;
    prod = prod / (longint'(VMS_UNITY) * VMS_UNITY);
    if (prod > longint'((1 << DAC_W) - 1)) begin
      prod = longint'((1 << DAC_W) - 1);
    end
    target_d = DAC_W'(prod);
  end

  // ==========================================================================
  // Delay and step sequencer
  vms_state_t state_q;
  logic [31:0] cnt_q;
  logic [31:0] step_cyc;
  logic [DAC_W-1:0] goal_q;

  assign step_cyc = 32'(VMS_STEP_BASE_CYC) << sst_q;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_q <= VMS_IDLE;
      cnt_q <= 32'h0;
      goal_q <= DAC_W'(NOMINAL_CODE);
    end else if (retarget) begin
      state_q <= VMS_WAIT;
      cnt_q <= 32'h0;
    end else begin
      unique case (state_q)
        VMS_IDLE: cnt_q <= 32'h0;
        VMS_WAIT: begin
          if (cnt_q >= 32'(START_DELAY_CYC - 1)) begin
            state_q <= VMS_SLEW;
            goal_q <= target_d;
            cnt_q <= 32'h0;
          end else begin
            cnt_q <= cnt_q + 32'h1;
          end
        end
        VMS_SLEW: begin
          goal_q <= target_d;
          if (ref_code == goal_q) begin
            state_q <= VMS_IDLE;
          end else if (cnt_q >= step_cyc - 32'h1) begin
            cnt_q <= 32'h0;
          end else begin
            cnt_q <= cnt_q + 32'h1;
          end
        end
        default: state_q <= VMS_IDLE;
      endcase
    end
  end

  // One step per interval toward the live goal
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ref_code <= DAC_W'(NOMINAL_CODE);
    end else if (state_q == VMS_SLEW && !retarget && cnt_q >= step_cyc - 32'h1) begin
      if (ref_code < goal_q) begin
        ref_code <= ref_code + 1'b1;
      end else if (ref_code > goal_q) begin
        ref_code <= ref_code - 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      target_code <= DAC_W'(NOMINAL_CODE);
    end else begin
      target_code <= target_d;
    end
  end

  assign slewing = state_q != VMS_IDLE;

  // ==========================================================================
  // Threshold decode and readback
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      uv_threshold_cv <= VMS_UV_4V25;
    end else begin
      unique case (thresh_q[2:0])
        3'h5: uv_threshold_cv <= VMS_UV_4V25;
        3'h6: uv_threshold_cv <= VMS_UV_6V0;
        3'h7: uv_threshold_cv <= VMS_UV_8V1;
        3'h4: uv_threshold_cv <= uv_threshold_cv;
        default: uv_threshold_cv <= VMS_UV_10V2;
      endcase
    end
  end

  assign supply_threshold_code = thresh_q[2:0];

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rd_data <= 8'h0;
    end else begin
      unique case (rd_cmd)
        VMS_CMD_MARGIN: rd_data <= margin_q;
        VMS_CMD_THRESHOLD: rd_data <= {5'h0, thresh_q[2:0]};
        VMS_CMD_FINE_TRIM: rd_data <= {3'h0, trim_q};
        VMS_CMD_SOFT_START: rd_data <= {4'h0, sst_q, 2'h0};
        VMS_CMD_OPERATION: rd_data <= {4'h0, margin_mode_q, 2'h0};
        default: rd_data <= 8'h0;
      endcase
    end
  end
endmodule : vms_ctrl
`default_nettype wire

// ==== tb/vms_chk.sv ====
// Port checker for the margin and slew control
`timescale 1ns/100ps
`default_nettype none
module vms_chk
  import vms_pkg::*;
#(
  parameter int DAC_W = 16
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire vms_wr_t wr,
  input wire logic [7:0] rd_cmd,
  input wire logic [7:0] rd_data,
  input wire logic [DAC_W-1:0] ref_code,
  input wire logic [DAC_W-1:0] target_code,
  input wire logic slewing,
  input wire logic [2:0] supply_threshold_code,
  input wire logic [9:0] uv_threshold_cv
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // ==========================================================
  // Helper state
  logic [1:0] sst_q;
  logic [15:0] gap_q;
  logic stepped_q;
  logic [DAC_W-1:0] prev_q;
  logic [9:0] uv_exp;
  always_ff @(posedge ref_clk) begin
    if (rst)
      sst_q <= 2'h0;
    else if (wr.valid && wr.cmd == VMS_CMD_SOFT_START)
      sst_q <= wr.data[3:2];
  end
  always_ff @(posedge ref_clk) begin
    prev_q <= ref_code;
    gap_q <= (ref_code != prev_q) ? 16'h0 : gap_q + 16'h1;
    stepped_q <= !rst && !wr.valid && slewing && (stepped_q || ref_code != prev_q);
  end
  always_comb begin
    case (supply_threshold_code)
      3'h5: uv_exp = 10'h1a9;
      3'h6: uv_exp = 10'h258;
      3'h7: uv_exp = 10'h32a;
      default: uv_exp = 10'h3fc;
    endcase
  end
  // ==========================================================
  // Assertions
  step_one_a: assert property ($changed(ref_code) |->
    ref_code + 1'b1 == $past(ref_code) || $past(ref_code) + 1'b1 == ref_code)
    else $error("reference moved by more than one step");
  step_pace_a: assert property (ref_code != prev_q && stepped_q |->
    gap_q == (32'd400 << sst_q) - 32'd1) else $error("step interval wrong");
  start_hold_a: assert property ($rose(slewing) |-> $stable(ref_code)[*8])
    else $error("reference moved before the start delay");
  move_cause_a: assert property ($changed(ref_code) |-> $past(slewing))
    else $error("reference moved while idle");
  settle_done_a: assert property ($fell(slewing) |-> ref_code == target_code)
    else $error("slewing ended away from target");
  idle_equal_a: assert property (!slewing && $stable(target_code) |->
    ref_code == target_code) else $error("idle reference differs from target");
  thresh_read_a: assert property (rd_cmd == VMS_CMD_THRESHOLD ##1
    $stable(supply_threshold_code) |-> rd_data[2:0] == supply_threshold_code)
    else $error("threshold readback wrong");
  uv_map_a: assert property (supply_threshold_code != 3'h4 ##1
    $stable(supply_threshold_code) |-> uv_threshold_cv == uv_exp)
    else $error("threshold level wrong");
  uv_keep_a: assert property (supply_threshold_code == 3'h4 [*2] |->
    $stable(uv_threshold_cv)) else $error("unsupported code changed level");
  cover property ($fell(slewing));
  cover property (ref_code != prev_q && stepped_q && sst_q == 2'h3);
  cover property (supply_threshold_code == 3'h4);
endmodule : vms_chk
`default_nettype wire

// ==== tb/vms_host.sv ====
// Bus host model issuing configuration writes
`timescale 1ns/100ps
`default_nettype none
module vms_host
  import vms_pkg::*;
(
  input wire logic ref_clk,
  output var vms_wr_t wr
);
  initial wr = '0;
  // One-cycle write pulse per command byte
  task automatic send(input logic [7:0] cmd, input logic [7:0] data);
    @(posedge ref_clk);
    wr <= '{1'b1, cmd, data};
    @(posedge ref_clk);
    wr <= '0;
    #1;
  endtask : send
endmodule : vms_host
`default_nettype wire

// ==== tb/vms_ctrl_tb_top.sv ====
// Testbench top for the margin and slew control
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin n_fail++; \
  $display("ERROR %s exp %h got %h", n, e, g); end end
module vms_ctrl_tb_top
  import vms_pkg::*;
;
  logic ref_clk;
  logic rst;
  logic [7:0] rd_cmd;
  logic [7:0] rd_data;
  logic [15:0] ref_code;
  logic [15:0] target_code;
  logic slewing;
  logic [2:0] supply_threshold_code;
  logic [9:0] uv_threshold_cv;
  vms_wr_t wr;
  int n_fail;
  int tests_run;
  vms_host u_host (.ref_clk(ref_clk), .wr(wr));
  vms_ctrl #(.START_DELAY_CYC(20)) u_dut (.ref_clk(ref_clk), .rst(rst), .wr(wr),
    .rd_cmd(rd_cmd), .rd_data(rd_data), .ref_code(ref_code), .target_code(target_code),
    .slewing(slewing), .supply_threshold_code(supply_threshold_code),
    .uv_threshold_cv(uv_threshold_cv));
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // ==========================================================
  // Shared tasks
  task automatic complete_run;
    $display("Checks %0d, failures %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : complete_run
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : tick
  task automatic rd_chk(input logic [7:0] c, input logic [7:0] e);
    @(posedge ref_clk);
    rd_cmd <= c;
    tick(2);
    `CHK("rd_data", e, rd_data)
  endtask : rd_chk
  task automatic wt(input logic [7:0] c, input logic [7:0] d, input logic [15:0] e);
    u_host.send(c, d);
    tick(3);
    `CHK("target_code", e, target_code)
  endtask : wt
  task automatic wait_chg(output int n);
    logic [15:0] r;
    r = ref_code;
    for (n = 0; ref_code === r && n < 9000; n++) tick(1);
    if (n >= 9000) begin
      n_fail++;
      complete_run();
    end
  endtask : wait_chg
  task automatic settle(input logic [15:0] e);
    int n;
    tick(2);
    for (n = 0; slewing !== 1'b0 && n < 20000; n++) tick(1);
    if (n >= 20000) begin
      n_fail++;
      complete_run();
    end
    `CHK("ref_code", e, ref_code)
  endtask : settle
  // ==========================================================
  // Scenarios
  task automatic t_reset;
    rd_chk(8'h7f, 8'h00);
    rd_chk(VMS_CMD_MARGIN, 8'h55);
    rd_chk(VMS_CMD_THRESHOLD, 8'h05);
    `CHK("ref_code", 16'h8000, ref_code)
    `CHK("target_code", 16'h8000, target_code)
    `CHK("slewing", 1'b0, slewing)
    `CHK("uv_threshold_cv", 10'h1a9, uv_threshold_cv)
    `CHK("supply_threshold_code", 3'h5, supply_threshold_code)
  endtask : t_reset
  task automatic t_uv;
    logic [2:0] c [5] = '{3'h7, 3'h6, 3'h4, 3'h1, 3'h5};
    logic [9:0] e [5] = '{10'h32a, 10'h258, 10'h258, 10'h3fc, 10'h1a9};
    for (int i = 0; i < 5; i++) begin
      u_host.send(VMS_CMD_THRESHOLD, {5'h1f, c[i]});
      tick(3);
      `CHK("uv_threshold_cv", e[i], uv_threshold_cv)
      `CHK("supply_threshold_code", c[i], supply_threshold_code)
    end
  endtask : t_uv
  task automatic t_slew;
    int n;
    wt(VMS_CMD_OPERATION, 8'h08, 16'h8604);
    tick(10);
    `CHK("ref_code", 16'h8000, ref_code)
    wait_chg(n);
    `CHK("delay", 407, n)
    `CHK("ref_code", 16'h8001, ref_code)
    wait_chg(n);
    `CHK("gap", 400, n)
    u_host.send(VMS_CMD_SOFT_START, 8'h0c);
    wait_chg(n);
    wait_chg(n);
    `CHK("gap", 3200, n)
    wt(VMS_CMD_MARGIN, 8'hc0, 16'h8f5c);
    wt(VMS_CMD_FINE_TRIM, 8'h1c, 16'h9c43);
    wt(VMS_CMD_OPERATION, 8'h04, 16'h8b85);
    wt(VMS_CMD_FINE_TRIM, 8'h10, 16'h8000);
    wt(VMS_CMD_MARGIN, 8'h55, 16'h7958);
    u_host.send(VMS_CMD_SOFT_START, 8'h00);
    wt(VMS_CMD_OPERATION, 8'h00, 16'h8000);
    settle(16'h8000);
  endtask : t_slew
  task automatic t_first;
    wt(VMS_CMD_MARGIN, 8'h45, 16'h8000);
    `CHK("slewing", 1'b0, slewing)
    rd_chk(VMS_CMD_MARGIN, 8'h45);
    wt(VMS_CMD_OPERATION, 8'h08, 16'h84bc);
    rd_chk(VMS_CMD_OPERATION, 8'h08);
    wt(VMS_CMD_OPERATION, 8'h00, 16'h8000);
    settle(16'h8000);
    rd_chk(VMS_CMD_FINE_TRIM, 8'h10);
  endtask : t_first
  initial begin
    rst = 1'b1;
    rd_cmd = 8'h00;
    n_fail = 0;
    tests_run = 0;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    t_reset();
    t_uv();
    t_slew();
    t_first();
    complete_run();
  end
endmodule : vms_ctrl_tb_top
bind vms_ctrl vms_chk #(.DAC_W(DAC_W)) u_chk (.ref_clk(ref_clk), .rst(rst), .wr(wr),
  .rd_cmd(rd_cmd), .rd_data(rd_data), .ref_code(ref_code), .target_code(target_code),
  .slewing(slewing), .supply_threshold_code(supply_threshold_code),
  .uv_threshold_cv(uv_threshold_cv));
`default_nettype wire
